// ==== rtl/quad_abz_map.vh ====
`ifndef QUAD_ABZ_MAP_VH
`define QUAD_ABZ_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CYC_LO 4'h0
`define OFS_CYC_MID 4'h1
`define OFS_CYC_HI 4'h2
`define OFS_IDX_CTL 4'h3
`define OFS_DIST_LAG 4'h4
`define OFS_OFFS_LO 4'h5
`define OFS_OFFS_MID 4'h6
`define OFS_OFFS_HI 4'h7
`define OFS_ENABLES 4'h8
`define OFS_HYST 4'h9
`define OFS_STATUS 4'ha
`define OFS_MASK 4'hb
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_DIR 0
`define BIT_ZPOL 1
`define BIT_STUP 2
`define BIT_ZMSK 3
`define BIT_FLEXIBLE_COUNT_DISABLE 0
`define BIT_EN 2
`define ST_LAG 0
`define ST_INDEX 1
`define RST_BYTE 8'h00
// ----------------------------------------
// minimum edge distance, in ps
// ----------------------------------------
`define MTD_PS_0 12500
`define MTD_PS_1 25000
`define MTD_PS_2 37500
`define MTD_PS_3 50000
`define MTD_PS_4 75000
`define MTD_PS_5 100000
`define MTD_PS_6 125000
`define MTD_PS_7 250000
`define MTD_PS_8 500000
`define MTD_PS_9 750000
`define MTD_PS_A 1000000
`define MTD_PS_B 1250000
`define MTD_PS_C 2500000
`define MTD_PS_D 5000000
`define MTD_PS_E 7500000
`define MTD_PS_F 10000000
`define CLK_PERIOD_PS 20000
`define PERIODS_MAX_CODE 4'h8
`define CLASSIC_EDGES 25'h0010000
`define FULL_EDGES 25'h1000000
`endif

// ==== rtl/quad_abz_gen.v ====
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "quad_abz_map.vh"

module quad_abz_gen (
   input wire clk_sys, // 50 MHz clock
   input wire reset, // sync, active high
   input wire [3:0] addr, // register index
   input wire [7:0] wr_data, // write data
   input wire wr_en, // write strobe
   input wire rd_en, // read strobe
   output reg [7:0] rd_data, // read data, next cycle
   input wire [15:0] interpolated_angle, // angle in period
   input wire [7:0] period_count, // period counter low bits
   input wire index_input_pos, // zero comparator plus
   input wire index_input_neg, // zero comparator minus
   input wire startup_active, // system in startup
   output reg quad_a, // A pin
   output reg quad_b, // B pin
   output reg index_z, // Z pin
   output reg quad_oe, // pin drive enable
   output reg quad_lag_error, // lag flag level
   output reg irq // interrupt level
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] cyc_lo_reg;
reg [7:0] cyc_mid_reg;
reg [7:0] cyc_hi_reg;
reg [7:0] idx_ctl_reg;
reg [7:0] dist_lag_reg;
reg [7:0] offs_lo_reg;
reg [7:0] offs_mid_reg;
reg [7:0] offs_hi_reg;
reg [7:0] enables_reg;
reg [7:0] hyst_reg;
reg [1:0] status_reg;
reg [1:0] mask_reg;

wire quad_output_enable = enables_reg[`BIT_EN];
wire flexible_count_disable = enables_reg[`BIT_FLEXIBLE_COUNT_DISABLE];
wire [21:0] quad_cycles_per_rev = {cyc_hi_reg[5:0], cyc_mid_reg, cyc_lo_reg};
wire quad_direction_reverse = idx_ctl_reg[`BIT_DIR];
wire index_polarity = idx_ctl_reg[`BIT_ZPOL];
wire quad_startup_mode = idx_ctl_reg[`BIT_STUP];
wire index_gate_select = idx_ctl_reg[`BIT_ZMSK];
wire [1:0] index_phase_state = idx_ctl_reg[5:4];
wire [1:0] index_pulse_length = idx_ctl_reg[7:6];
wire [3:0] min_edge_distance = dist_lag_reg[3:0];
wire [1:0] lag_threshold = dist_lag_reg[5:4];
wire [23:0] quad_position_offset = {offs_hi_reg, offs_mid_reg, offs_lo_reg};
wire [3:0] angle_hysteresis = hyst_reg[3:0];
wire [3:0] periods_per_rev_code = hyst_reg[7:4];

// ----------------------------------------
// edge distance in clock cycles
// ----------------------------------------
function [9:0] mtd_cycles;
   input [3:0] code;
   reg [31:0] ps;
   begin
      case (code)
         4'h0: ps = `MTD_PS_0;
         4'h1: ps = `MTD_PS_1;
         4'h2: ps = `MTD_PS_2;
         4'h3: ps = `MTD_PS_3;
         4'h4: ps = `MTD_PS_4;
         4'h5: ps = `MTD_PS_5;
         4'h6: ps = `MTD_PS_6;
         4'h7: ps = `MTD_PS_7;
         4'h8: ps = `MTD_PS_8;
         4'h9: ps = `MTD_PS_9;
         4'ha: ps = `MTD_PS_A;
         4'hb: ps = `MTD_PS_B;
         4'hc: ps = `MTD_PS_C;
         4'hd: ps = `MTD_PS_D;
         4'he: ps = `MTD_PS_E;
         default: ps = `MTD_PS_F;
      endcase
      ps = (ps + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS; // least time, round up
      mtd_cycles = ps[9:0];
   end
endfunction

// ----------------------------------------
// mechanical position
// ----------------------------------------
// revolution span select
wire [3:0] pr_code = (periods_per_rev_code > `PERIODS_MAX_CODE) ?
   `PERIODS_MAX_CODE : periods_per_rev_code;
wire [3:0] pr_shift = `PERIODS_MAX_CODE - pr_code;
wire [23:0] mech_raw = {period_count, interpolated_angle};
wire [23:0] mech_pos = mech_raw << pr_shift;
wire [23:0] pos_offs = mech_pos + quad_position_offset;

// ----------------------------------------
// hysteresis
// ----------------------------------------
reg [23:0] hpos_reg;
reg hdir_down_reg;
wire [23:0] hyst_width = (angle_hysteresis == 4'h0) ? 24'h000000 :
   (angle_hysteresis > 4'h9) ? 24'h040000 :
   (24'h000200 << angle_hysteresis);
wire [23:0] hdelta = pos_offs - hpos_reg;
wire [23:0] hback = hpos_reg - pos_offs;
wire h_up = (hdelta != 24'h000000) && !hdelta[23];
wire h_down = (hback != 24'h000000) && !hback[23];

always @(posedge clk_sys)
begin
   if (reset)
   begin
      hpos_reg <= 24'h000000;
      hdir_down_reg <= 1'b0;
   end
   else if (hyst_width == 24'h000000)
   begin
      hpos_reg <= pos_offs;
   end
   else if (!hdir_down_reg)
   begin
      if (h_up)
         hpos_reg <= pos_offs;
      else if (h_down && (hback >= hyst_width))
      begin
         hpos_reg <= pos_offs;
         hdir_down_reg <= 1'b1;
      end
   end
   else
   begin
      if (h_down)
         hpos_reg <= pos_offs;
      else if (h_up && (hdelta >= hyst_width))
      begin
         hpos_reg <= pos_offs;
         hdir_down_reg <= 1'b0;
      end
   end
end

// ----------------------------------------
// target edge count
// ----------------------------------------
// zero selects 2^22 cycles
wire [24:0] flex_edges = (quad_cycles_per_rev == 22'h000000) ?
   `FULL_EDGES : {1'b0, quad_cycles_per_rev, 2'b00};
wire [24:0] edges = flexible_count_disable ? `CLASSIC_EDGES : flex_edges;
wire [48:0] scaled = hpos_reg * flex_edges;
wire [24:0] target = flexible_count_disable ?
   {9'h000, hpos_reg[23:8]} : scaled[48:24];
reg [24:0] target_reg;
reg [24:0] edges_reg;

always @(posedge clk_sys)
begin
   if (reset)
   begin
      target_reg <= 25'h0000000;
      edges_reg <= `FULL_EDGES;
   end
   else
   begin
      target_reg <= target;
      edges_reg <= edges;
   end
end

// ----------------------------------------
// tracking and edge pacing
// ----------------------------------------
reg [24:0] out_reg;
reg [9:0] gap_reg;
reg [26:0] d_wrap;
reg [26:0] lag_mag;
reg [24:0] out_next;
wire [26:0] d_raw = {2'b00, target_reg} - {2'b00, out_reg};
wire [26:0] e_half = {3'b000, edges_reg[24:1]};
wire [26:0] e_full = {2'b00, edges_reg};
wire run = quad_output_enable && (quad_startup_mode || !startup_active);

always @*
begin
   d_wrap = d_raw;
   if (!d_raw[26] && (d_raw > e_half))
      d_wrap = d_raw - e_full;
   else if (d_raw[26] && ((27'h0 - d_raw) > e_half))
      d_wrap = d_raw + e_full;
   lag_mag = d_wrap[26] ? (27'h0 - d_wrap) : d_wrap;
   if (d_wrap[26])
      out_next = (out_reg == 25'h0) ? edges_reg - 25'h1 : out_reg - 25'h1;
   else
      out_next = (out_reg + 25'h1 >= edges_reg) ? 25'h0 : out_reg + 25'h1;
end

wire step_req = (d_wrap != 27'h0);
wire gap_done = (gap_reg == 10'h000);
wire step = run && step_req && gap_done;

always @(posedge clk_sys)
begin
   if (reset)
   begin
      out_reg <= 25'h0000000;
      gap_reg <= 10'h000;
   end
   else if (!run)
   begin
      out_reg <= target_reg;
      gap_reg <= 10'h000;
   end
   else if (step)
   begin
      out_reg <= out_next;
      gap_reg <= mtd_cycles(min_edge_distance) - 10'h001;
   end
   else if (!gap_done)
   begin
      gap_reg <= gap_reg - 10'h001;
   end
end

// ----------------------------------------
// lag monitor
// ----------------------------------------
wire [26:0] lag_thr = e_full >> (3'h5 - {1'b0, lag_threshold});
wire lag_event = run && (lag_threshold != 2'b00) && (lag_mag >= lag_thr);
wire index_event = step && (out_next == 25'h0);

// ----------------------------------------
// pin outputs
// ----------------------------------------
reg [1:0] ph_idx;
reg [1:0] seq_idx;
reg [1:0] ab_val;

always @*
begin
   case (index_phase_state)
      2'b00: ph_idx = 2'd0;
      2'b10: ph_idx = 2'd1;
      2'b11: ph_idx = 2'd2;
      default: ph_idx = 2'd3;
   endcase
   if (quad_direction_reverse)
      seq_idx = ph_idx - out_reg[1:0];
   else
      seq_idx = ph_idx + out_reg[1:0];
   case (seq_idx)
      2'd0: ab_val = 2'b00;
      2'd1: ab_val = 2'b10;
      2'd2: ab_val = 2'b11;
      default: ab_val = 2'b01;
   endcase
end

// index spans 1 to 4 increments
wire z_window = (out_reg <= {23'h0, index_pulse_length});
wire z_gate = !index_gate_select || (index_input_pos && !index_input_neg);
wire z_act = z_window && z_gate;

always @(posedge clk_sys)
begin
   if (reset)
   begin
      quad_a <= 1'b0;
      quad_b <= 1'b0;
      index_z <= 1'b0;
      quad_oe <= 1'b0;
   end
   else if (!quad_output_enable)
   begin
      quad_a <= 1'b0;
      quad_b <= 1'b0;
      index_z <= index_polarity;
      quad_oe <= 1'b0;
   end
   else
   begin
      quad_oe <= 1'b1;
      if (run)
      begin
         quad_a <= ab_val[1];
         quad_b <= ab_val[0];
         index_z <= z_act ^ index_polarity;
      end
      else
      begin
         quad_a <= 1'b0;
         quad_b <= 1'b0;
         index_z <= index_polarity;
      end
   end
end

// ----------------------------------------
// register bus
// ----------------------------------------
wire wr_status = wr_en && (addr == `OFS_STATUS);
wire [1:0] ev_set = {index_event, lag_event};

always @(posedge clk_sys)
begin
   if (reset)
   begin
      cyc_lo_reg <= `RST_BYTE;
      cyc_mid_reg <= `RST_BYTE;
      cyc_hi_reg <= `RST_BYTE;
      idx_ctl_reg <= `RST_BYTE;
      dist_lag_reg <= `RST_BYTE;
      offs_lo_reg <= `RST_BYTE;
      offs_mid_reg <= `RST_BYTE;
      offs_hi_reg <= `RST_BYTE;
      enables_reg <= `RST_BYTE;
      hyst_reg <= `RST_BYTE;
      mask_reg <= 2'b00;
   end
   else if (wr_en)
   begin
      case (addr)
         `OFS_CYC_LO: cyc_lo_reg <= wr_data;
         `OFS_CYC_MID: cyc_mid_reg <= wr_data;
         `OFS_CYC_HI: cyc_hi_reg <= {2'b00, wr_data[5:0]};
         `OFS_IDX_CTL: idx_ctl_reg <= wr_data;
         `OFS_DIST_LAG: dist_lag_reg <= {2'b00, wr_data[5:0]};
         `OFS_OFFS_LO: offs_lo_reg <= wr_data;
         `OFS_OFFS_MID: offs_mid_reg <= wr_data;
         `OFS_OFFS_HI: offs_hi_reg <= wr_data;
         `OFS_ENABLES: enables_reg <= {5'h00, wr_data[2], 1'b0, wr_data[0]};
         `OFS_HYST: hyst_reg <= wr_data;
         `OFS_MASK: mask_reg <= wr_data[1:0];
         default: ;
      endcase
   end
end

// sticky events, set beats write-one clear
always @(posedge clk_sys)
begin
   if (reset)
   begin
      status_reg <= 2'b00;
      quad_lag_error <= 1'b0;
      irq <= 1'b0;
   end
   else
   begin
      status_reg <= ev_set | (status_reg & ~(wr_status ? wr_data[1:0] : 2'b00));
      quad_lag_error <= lag_event | (status_reg[`ST_LAG] &
         ~(wr_status & wr_data[`ST_LAG]));
      irq <= |((ev_set | (status_reg & ~(wr_status ? wr_data[1:0] : 2'b00)))
         & mask_reg);
   end
end

always @(posedge clk_sys)
begin
   if (reset)
      rd_data <= 8'h00;
   else if (rd_en)
   begin
      case (addr)
         `OFS_CYC_LO: rd_data <= cyc_lo_reg;
         `OFS_CYC_MID: rd_data <= cyc_mid_reg;
         `OFS_CYC_HI: rd_data <= cyc_hi_reg;
         `OFS_IDX_CTL: rd_data <= idx_ctl_reg;
         `OFS_DIST_LAG: rd_data <= dist_lag_reg;
         `OFS_OFFS_LO: rd_data <= offs_lo_reg;
         `OFS_OFFS_MID: rd_data <= offs_mid_reg;
         `OFS_OFFS_HI: rd_data <= offs_hi_reg;
         `OFS_ENABLES: rd_data <= enables_reg;
         `OFS_HYST: rd_data <= hyst_reg;
         `OFS_STATUS: rd_data <= {6'h00, status_reg};
         `OFS_MASK: rd_data <= {6'h00, mask_reg};
         default: rd_data <= 8'h00;
      endcase
   end
   else
      rd_data <= 8'h00;
end

endmodule // quad_abz_gen

`default_nettype wire

// ==== sim/quad_abz_gen_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module quad_abz_chk (
   input wire logic clk_sys, // clock
   input wire logic reset, // sync reset
   input wire logic [3:0] addr, // index
   input wire logic [7:0] wr_data, // data
   input wire logic wr_en, // write
   input wire logic rd_en, // read
   input wire logic [7:0] rd_data, // read data
   input wire logic quad_a, // A pin
   input wire logic quad_b, // B pin
   input wire logic quad_oe, // drive enable
   input wire logic quad_lag_error, // lag flag
   input wire logic irq // interrupt
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   a_pins_idle_off:
      assert property (!quad_oe |-> !quad_a && !quad_b)
      else $error("pins moved while off");
   a_enable_opens:
      assert property (wr_en && addr == 4'h8 && wr_data[2] |=> ##[0:1] quad_oe)
      else $error("enable not seen");
   a_disable_closes:
      assert property (wr_en && addr == 4'h8 && !wr_data[2] |=> ##[0:1] !quad_oe)
      else $error("disable not seen");
   a_gray_one_step:
      assert property (quad_oe && $past(quad_oe) && quad_a != $past(quad_a)
         && !($past(wr_en, 2) && $past(addr, 2) == 4'h3)
         |-> quad_b == $past(quad_b))
      else $error("both lines moved");
   a_lag_sticky_hold:
      assert property (quad_lag_error && !(wr_en && addr == 4'ha && wr_data[0])
         |=> quad_lag_error)
      else $error("lag flag dropped");
   a_lag_needs_run:
      assert property ($rose(quad_lag_error) |-> quad_oe)
      else $error("lag flag while off");
   a_irq_masked_off:
      assert property ((wr_en && addr == 4'hb && wr_data[1:0] == 2'b00)
         ##1 (!(wr_en && addr == 4'hb))[*2] |-> !irq)
      else $error("irq with mask clear");
   a_read_one_cycle:
      assert property (!$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data held");
endmodule // quad_abz_chk
`default_nettype wire

// ==== sim/quad_counter_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module quad_counter_model (
   input wire logic clk_sys, // clock
   input wire logic clear, // restart counts
   input wire logic quad_a, // A line
   input wire logic quad_b, // B line
   output logic [15:0] count, // net steps
   output logic [7:0] bad_steps, // illegal moves
   output logic [15:0] min_gap // shortest spacing
);
   logic [15:0] gap;
   logic a_q;
   logic b_q;
   // ------------------------------
   // decoder
   // ------------------------------
   // samples every clock
   always @(posedge clk_sys)
   begin
      a_q <= quad_a;
      b_q <= quad_b;
      if (gap != 16'hffff)
         gap <= gap + 16'h0001;
      // first edge after clear has no spacing
      if (clear)
      begin
         count <= 16'h0000;
         bad_steps <= 8'h00;
         min_gap <= 16'hffff;
         gap <= 16'hffff;
      end
      else if ({quad_a, quad_b} != {a_q, b_q})
      begin
         gap <= 16'h0001;
         if (gap < min_gap)
            min_gap <= gap;
         if ({quad_a, quad_b} == {~b_q, a_q})
            count <= count + 16'h0001;
         else if ({quad_a, quad_b} == {b_q, ~a_q})
            count <= count - 16'h0001;
         else
            bad_steps <= bad_steps + 8'h01;
      end
   end
endmodule // quad_counter_model
`default_nettype wire

// ==== sim/tb_quad_abz_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_quad_abz_generator;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [15:0] interpolated_angle = 16'h0000;
   logic [7:0] period_count = 8'h00;
   logic index_input_pos = 1'b0;
   logic index_input_neg = 1'b0;
   logic startup_active = 1'b0;
   logic clear = 1'b1;
   wire [7:0] rd_data;
   wire quad_a;
   wire quad_b;
   wire index_z;
   wire quad_oe;
   wire quad_lag_error;
   wire irq;
   wire [15:0] count;
   wire [7:0] bad_steps;
   wire [15:0] min_gap;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   logic [7:0] ctl;
   logic [1:0] n;
   logic [7:0] msk [16] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff,
      8'h05, 8'hff, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
   quad_abz_gen dut (.clk_sys, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
      .interpolated_angle, .period_count, .index_input_pos, .index_input_neg,
      .startup_active, .quad_a, .quad_b, .index_z, .quad_oe, .quad_lag_error, .irq);
   quad_counter_model far (.clk_sys, .clear, .quad_a, .quad_b, .count, .bad_steps,
      .min_gap);
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         err_count = err_count + 1;
         end_of_test();
      end
   end
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks = checks + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 cmp($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd_data});
      @(posedge clk_sys);
   endtask
   task automatic pins(input int w, input logic [2:0] e, input string what);
      repeat (w) @(posedge clk_sys);
      #1 cmp(what, {13'h0, e}, {13'h0, quad_a, quad_b, index_z});
   endtask
   task automatic pulse_clear();
      clear <= 1'b1;
      repeat (20) @(posedge clk_sys);
      clear <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------
   // tests
   // ------------------------------
   initial
   begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1 cmp("oe", 16'h0, {15'h0, quad_oe});
      for (int i = 0; i < 16; i++)
      begin
         rd(i[3:0], 8'h00);
         wr(i[3:0], 8'hff);
         rd(i[3:0], msk[i]);
         wr(i[3:0], 8'h00);
      end
      wr(4'h0, 8'h01);
      wr(4'h8, 8'h04);
      for (int k = 0; k < 16; k++)
      begin
         ctl = {k[1:0], k[3:2], 2'b00, k[0], k[3] ^ k[1]};
         wr(4'h3, ctl);
         interpolated_angle <= 16'h2000;
         pulse_clear();
         for (int q = 0; q < 5; q++)
         begin
            interpolated_angle <= {q[1:0], 14'h2000};
            n = {ctl[4], ctl[5] ^ ctl[4]};
            n = ctl[0] ? n - q[1:0] : n + q[1:0];
            pins(12, {n[1] ^ n[0], n[1], ((q % 4) <= k[1:0]) ^ ctl[1]}, "abz");
         end
         cmp("count", ctl[0] ? 16'hfffc : 16'h0004, count);
         cmp("bad", 16'h0, {8'h0, bad_steps});
      end
      wr(4'h3, 8'hc8);
      pins(12, 3'b000, "zmask");
      index_input_pos <= 1'b1;
      pins(12, 3'b001, "zmask");
      index_input_neg <= 1'b1;
      pins(12, 3'b000, "zmask");
      wr(4'h3, 8'h00);
      wr(4'h9, 8'h10);
      period_count <= 8'h01;
      pins(12, 3'b110, "periods");
      wr(4'h9, 8'h00);
      period_count <= 8'h00;
      wr(4'h7, 8'h40);
      pins(12, 3'b100, "offset");
      wr(4'h7, 8'h00);
      startup_active <= 1'b1;
      pins(12, 3'b000, "startup");
      cmp("oe", 16'h1, {15'h0, quad_oe});
      wr(4'h3, 8'h04);
      pins(12, 3'b001, "startup");
      startup_active <= 1'b0;
      wr(4'h3, 8'h00);
      wr(4'h4, 8'h07);
      pulse_clear();
      interpolated_angle <= 16'ha000;
      repeat (60) @(posedge clk_sys);
      cmp("steps", 16'h2, count);
      cmp("gap", 16'd13, min_gap);
      wr(4'h8, 8'h00);
      wr(4'h1, 8'h01);
      wr(4'h0, 8'h00);
      wr(4'h4, 8'h00);
      interpolated_angle <= 16'h0000;
      wr(4'h8, 8'h04);
      repeat (1500) @(posedge clk_sys);
      wr(4'h4, 8'h10);
      wr(4'ha, 8'hff);
      interpolated_angle <= 16'h4000;
      repeat (100) @(posedge clk_sys);
      #1 cmp("lag irq", 16'h2, {14'h0, quad_lag_error, irq});
      repeat (300) @(posedge clk_sys);
      rd(4'ha, 8'h01);
      wr(4'hb, 8'h01);
      #1 cmp("irq", 16'h1, {15'h0, irq});
      wr(4'ha, 8'h01);
      repeat (2) @(posedge clk_sys);
      #1 cmp("lag irq", 16'h0, {14'h0, quad_lag_error, irq});
      wr(4'hb, 8'h02);
      interpolated_angle <= 16'h0000;
      repeat (400) @(posedge clk_sys);
      #1 cmp("irq", 16'h1, {15'h0, irq});
      rd(4'ha, 8'h03);
      wr(4'h9, 8'h09);
      pulse_clear();
      interpolated_angle <= 16'h0800;
      repeat (60) @(posedge clk_sys);
      cmp("hyst fwd", 16'd32, count);
      interpolated_angle <= 16'h0500;
      repeat (60) @(posedge clk_sys);
      cmp("hyst hold", 16'd32, count);
      interpolated_angle <= 16'h0300;
      repeat (60) @(posedge clk_sys);
      cmp("hyst back", 16'd12, count);
      interpolated_angle <= 16'h0600;
      repeat (60) @(posedge clk_sys);
      cmp("hyst slip", 16'd12, count);
      interpolated_angle <= 16'h0000;
      wr(4'h9, 8'h00);
      repeat (60) @(posedge clk_sys);
      wr(4'h8, 8'h05);
      pulse_clear();
      interpolated_angle <= 16'h0010;
      repeat (40) @(posedge clk_sys);
      cmp("classic", 16'd16, count);
      interpolated_angle <= 16'h0000;
      repeat (40) @(posedge clk_sys);
      wr(4'h8, 8'h04);
      wr(4'h1, 8'h00);
      pulse_clear();
      interpolated_angle <= 16'h0001;
      repeat (300) @(posedge clk_sys);
      cmp("cpr zero", 16'd256, count);
      end_of_test();
   end
endmodule // tb_quad_abz_generator
bind quad_abz_gen quad_abz_chk chk (.clk_sys, .reset, .addr, .wr_data, .wr_en, .rd_en,
   .rd_data, .quad_a, .quad_b, .quad_oe, .quad_lag_error, .irq);
`default_nettype wire
